// ---- core/mlmb_core.sv ----
/*
  Mode latch, port registers and multiplexed expansion bus engine.
  Assumes E and the address strobe come from outside and are sampled here,
  and that a single requester issues bus cycles over the request port.
*/
// Added by the designer: strobed register access and the register offsets.
// Summary of operation
// - The two mode select pins of port two are caught into two mode bits as reset rises.
// - Port two data reads give zero in bit 7, the mode bits in 6 and 5, pin levels in 4 to 0.
// - Both select pins high selects mux mode 3 with no internal RAM and external vectors.
// - Upper pin high and lower low selects mux mode 2 with internal RAM and external vectors.
// - Both modes address 64K bytes and port four always drives the high address byte.
// - Port three carries the low address until the strobe falls, then data while E is high in external cycles only.
// - Ports one and two have a write only direction register and a data register.
// - A set direction bit makes the pin an output, a clear bit an input.
// - The high address port is address only and has no direction or data register.
// - There are one 10 bit, two 8 bit and one 5 bit port.
`timescale 1ns/1ps
`include "mlmb_defs.svh"

module mlmb_core
  import mlmb_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        ce,
  input  wire logic [`MLMB_REG_AW-1:0]     reg_addr,
  input  wire logic [`MLMB_AD_W-1:0]       reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [`MLMB_AD_W-1:0]       reg_rdata_q,
  input  wire logic                        bus_req,
  input  wire logic [`MLMB_ADDR_W-1:0]     bus_addr,
  input  wire logic                        bus_we,
  input  wire logic [`MLMB_AD_W-1:0]       bus_wdata,
  output logic                             bus_busy_q,
  output logic                             bus_done_q,
  output logic      [`MLMB_AD_W-1:0]       bus_rdata_q,
  input  wire logic                        e_clk,
  input  wire logic                        address_latch_strobe,
  input  wire logic [`MLMB_P1_W-1:0]       port_one_in,
  output logic      [`MLMB_P1_W-1:0]       port_one_out_q,
  output logic      [`MLMB_P1_W-1:0]       port_one_oe_q,
  input  wire logic [`MLMB_P2_W-1:0]       port_two_in,
  output logic      [`MLMB_P2_W-1:0]       port_two_out_q,
  output logic      [`MLMB_P2_W-1:0]       port_two_oe_q,
  input  wire logic [`MLMB_P3_W-1:0]       port_three_in,
  output logic      [`MLMB_P3_W-1:0]       port_three_out_q,
  output logic      [`MLMB_P3_W-1:0]       port_three_oe_q,
  output logic      [`MLMB_P4_W-1:0]       port_four_out_q,
  output logic      [1:0]                  mode_bits_q,
  output logic                             ram_enable_q,
  output logic                             mode_undefined_q
);

  logic                      rst_meta_q;
  logic                      rst_n;
  logic [1:0]                e_sync_q;
  logic [1:0]                as_sync_q;
  logic                      e_prev_q;
  logic                      as_prev_q;
  logic [`MLMB_P1_W-1:0]     p1_meta_q;
  logic [`MLMB_P1_W-1:0]     p1_sync_q;
  logic [`MLMB_P2_W-1:0]     p2_meta_q;
  logic [`MLMB_P2_W-1:0]     p2_sync_q;
  logic [`MLMB_AD_W-1:0]     p3_meta_q;
  logic [`MLMB_AD_W-1:0]     p3_sync_q;
  logic                      caught_q;
  mlmb_bus_state_t           st_q;
  logic [`MLMB_ADDR_W-1:0]   cur_addr_q;
  logic                      cur_we_q;
  logic [`MLMB_AD_W-1:0]     cur_wdata_q;
  logic                      int_q;
  logic                      e_rise;
  logic                      e_fall;
  logic                      as_rise;
  logic                      as_fall;
  logic                      ram_we;
  logic [`MLMB_AD_W-1:0]     ram_rdata;

  // Edge of a sampled level, given its present and last value
  function automatic logic rose_of(input logic cur, input logic prev);
    rose_of = cur & ~prev;
  endfunction : rose_of

  // Internal RAM decode; vectors at the top of memory never hit it
  function automatic logic ram_hit(input logic [`MLMB_ADDR_W-1:0] a, input logic en);
    ram_hit = en && (a[`MLMB_ADDR_W-1:`MLMB_RAM_AW] == `MLMB_RAM_BASE_HI);
  endfunction : ram_hit

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // Pin synchronisers on the raw reset, so they are filled before rst_n lets go
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      e_sync_q  <= 2'h0;
      as_sync_q <= 2'h0;
      p1_meta_q <= `MLMB_BYTE_RST;
      p1_sync_q <= `MLMB_BYTE_RST;
      p2_meta_q <= 5'h00;
      p2_sync_q <= 5'h00;
      p3_meta_q <= `MLMB_BYTE_RST;
      p3_sync_q <= `MLMB_BYTE_RST;
    end else if (ce) begin
      e_sync_q  <= {e_sync_q[0], e_clk};
      as_sync_q <= {as_sync_q[0], address_latch_strobe};
      p1_meta_q <= port_one_in;
      p1_sync_q <= p1_meta_q;
      p2_meta_q <= port_two_in;
      p2_sync_q <= p2_meta_q;
      p3_meta_q <= port_three_in[`MLMB_AD_W-1:0];
      p3_sync_q <= p3_meta_q;
    end
  end

  // Last values of the synchronised strobes for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      e_prev_q  <= 1'b0;
      as_prev_q <= 1'b0;
    end else if (ce) begin
      e_prev_q  <= e_sync_q[1];
      as_prev_q <= as_sync_q[1];
    end
  end

  assign e_rise  = rose_of(e_sync_q[1], e_prev_q);
  assign e_fall  = rose_of(e_prev_q, e_sync_q[1]);
  assign as_rise = rose_of(as_sync_q[1], as_prev_q);
  assign as_fall = rose_of(as_prev_q, as_sync_q[1]);

  // Mode latch: first enabled cycle after release, then frozen until next reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      caught_q         <= 1'b0;
      mode_bits_q      <= 2'h0;
      ram_enable_q     <= 1'b0;
      mode_undefined_q <= 1'b0;
    end else if (ce && !caught_q) begin
      caught_q         <= 1'b1;
      mode_bits_q      <= p2_sync_q[1:0];
      ram_enable_q     <= (p2_sync_q[1:0] == `MLMB_MODE_MUX_RAM);
      mode_undefined_q <= ~p2_sync_q[1];
    end
  end

  // Direction and data registers; the direction register is the pin enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_one_oe_q  <= `MLMB_BYTE_RST;
      port_two_oe_q  <= 5'h00;
      port_one_out_q <= `MLMB_BYTE_RST;
      port_two_out_q <= 5'h00;
    end else if (ce && reg_wr) begin
      unique case (reg_addr)
        `MLMB_OFF_P1_DDR:  port_one_oe_q  <= reg_wdata;
        `MLMB_OFF_P2_DDR:  port_two_oe_q  <= reg_wdata[`MLMB_P2_W-1:0];
        `MLMB_OFF_P1_DATA: port_one_out_q <= reg_wdata;
        `MLMB_OFF_P2_DATA: port_two_out_q <= reg_wdata[`MLMB_P2_W-1:0];
        default: ;
      endcase
    end
  end

  // Read data stand one cycle only; direction registers read as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= `MLMB_BYTE_RST;
    end else if (ce) begin
      reg_rdata_q <= `MLMB_BYTE_RST;
      if (reg_rd) begin
        unique case (reg_addr)
          `MLMB_OFF_P1_DATA: reg_rdata_q <= (port_one_oe_q & port_one_out_q) |
                                            (~port_one_oe_q & p1_sync_q);
          `MLMB_OFF_P2_DATA: reg_rdata_q <= {1'b0, mode_bits_q, p2_sync_q};
          default:           reg_rdata_q <= `MLMB_BYTE_RST;
        endcase
      end
    end
  end

  // Request capture; a request while busy is ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_busy_q  <= 1'b0;
      cur_addr_q  <= 16'h0000;
      cur_we_q    <= 1'b0;
      cur_wdata_q <= `MLMB_BYTE_RST;
    end else if (ce) begin
      if (!bus_busy_q && bus_req) begin
        bus_busy_q  <= 1'b1;
        cur_addr_q  <= bus_addr;
        cur_we_q    <= bus_we;
        cur_wdata_q <= bus_wdata;
      end else if (st_q == BUS_DATA && e_fall) begin
        bus_busy_q  <= 1'b0;
      end
    end
  end

  // Bus engine; cycles follow the outside strobes, so no timing is made here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q             <= BUS_IDLE;
      port_three_out_q <= `MLMB_P3_OUT_RST;
      port_three_oe_q  <= 10'h000;
      port_four_out_q  <= `MLMB_BYTE_RST;
      int_q            <= 1'b0;
      bus_done_q       <= 1'b0;
      bus_rdata_q      <= `MLMB_BYTE_RST;
    end else if (ce) begin
      bus_done_q <= 1'b0;
      port_three_oe_q[`MLMB_P3_EXT_BIT:`MLMB_P3_RW_BIT] <= 2'h3;
      unique case (st_q)
        BUS_IDLE: begin
          if (bus_busy_q && as_rise) begin
            port_four_out_q <= cur_addr_q[15:8];
            port_three_out_q <= {~ram_hit(cur_addr_q, ram_enable_q), ~cur_we_q,
                                 cur_addr_q[7:0]};
            port_three_oe_q[`MLMB_AD_W-1:0] <= 8'hff;
            int_q <= ram_hit(cur_addr_q, ram_enable_q);
            st_q  <= BUS_ADDR;
          end
        end
        BUS_ADDR: begin
          // Address held until the strobe's falling edge has been seen
          if (as_fall) begin
            port_three_oe_q[`MLMB_AD_W-1:0] <= 8'h00;
            st_q <= BUS_DATA;
          end
        end
        BUS_DATA: begin
          if (e_rise && cur_we_q && !int_q) begin
            port_three_out_q[`MLMB_AD_W-1:0] <= cur_wdata_q;
            port_three_oe_q[`MLMB_AD_W-1:0]  <= 8'hff;
          end
          if (e_fall) begin
            port_three_oe_q[`MLMB_AD_W-1:0] <= 8'h00;
            port_three_out_q[`MLMB_P3_EXT_BIT:`MLMB_P3_RW_BIT] <= 2'h1;
            bus_done_q <= 1'b1;
            if (!cur_we_q) begin
              bus_rdata_q <= int_q ? ram_rdata : p3_sync_q;
            end
            st_q <= BUS_IDLE;
          end
        end
      endcase
    end
  end

  // Internal RAM written at the end of E high, read continuously
  assign ram_we = (st_q == BUS_DATA) && e_fall && int_q && cur_we_q;

  mlmb_ram u_ram (
    .clk     (clk),
    .ce      (ce),
    .we      (ram_we),
    .addr    (cur_addr_q[`MLMB_RAM_AW-1:0]),
    .wdata   (cur_wdata_q),
    .rdata_q (ram_rdata)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_mode_capture;
    $rose(caught_q) |-> mode_bits_q == $past(p2_sync_q[1:0]);
  endproperty
  a_mode_capture: assert property (p_mode_capture)
    else $error("mode bits differ from select pins at reset release");

  property p_mode_hold;
    caught_q && $past(caught_q) |-> $stable(mode_bits_q) && $stable(ram_enable_q);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode bits changed during operation");

  property p_p2_read;
    ce && reg_rd && reg_addr == `MLMB_OFF_P2_DATA
      |=> reg_rdata_q == {1'b0, $past(mode_bits_q), $past(p2_sync_q)};
  endproperty
  a_p2_read: assert property (p_p2_read)
    else $error("port two data read has wrong layout");

  property p_mode3;
    caught_q && mode_bits_q == `MLMB_MODE_MUX_NORAM |-> !ram_enable_q;
  endproperty
  a_mode3: assert property (p_mode3)
    else $error("internal RAM enabled in mode 3");

  property p_mode2;
    caught_q && mode_bits_q == `MLMB_MODE_MUX_RAM |-> ram_enable_q;
  endproperty
  a_mode2: assert property (p_mode2)
    else $error("internal RAM disabled in mode 2");

  property p_high_addr;
    st_q != BUS_IDLE |-> port_four_out_q == cur_addr_q[15:8];
  endproperty
  a_high_addr: assert property (p_high_addr)
    else $error("port four does not show the high address byte");

  property p_high_only_bus;
    $changed(port_four_out_q) |-> $past(st_q == BUS_IDLE && bus_busy_q && as_rise && ce);
  endproperty
  a_high_only_bus: assert property (p_high_only_bus)
    else $error("port four changed outside a bus cycle start");

  property p_addr_phase;
    st_q == BUS_ADDR |-> port_three_oe_q[7:0] == 8'hff
                         && port_three_out_q[7:0] == cur_addr_q[7:0];
  endproperty
  a_addr_phase: assert property (p_addr_phase)
    else $error("low address not driven during strobe phase");

  property p_addr_release;
    ce && st_q == BUS_ADDR && as_fall |=> st_q == BUS_DATA ##0 port_three_oe_q[7:0] == 8'h00;
  endproperty
  a_addr_release: assert property (p_addr_release)
    else $error("shared lines not released after strobe fall");

  property p_write_data;
    st_q == BUS_DATA && port_three_oe_q[0]
      |-> cur_we_q && !int_q && port_three_out_q[7:0] == cur_wdata_q;
  endproperty
  a_write_data: assert property (p_write_data)
    else $error("shared lines driven with wrong data");

  property p_ddr_write;
    ce && reg_wr && reg_addr == `MLMB_OFF_P1_DDR |=> port_one_oe_q == $past(reg_wdata);
  endproperty
  a_ddr_write: assert property (p_ddr_write)
    else $error("port one enables do not follow direction write");

  property p_ddr_read;
    ce && reg_rd && reg_addr == `MLMB_OFF_P2_DDR |=> reg_rdata_q == 8'h00;
  endproperty
  a_ddr_read: assert property (p_ddr_read)
    else $error("direction register is readable");

  c_mode2: cover property ($rose(caught_q) && p2_sync_q[1:0] == `MLMB_MODE_MUX_RAM);
  c_ext_read: cover property (bus_done_q && !cur_we_q && !int_q);
  c_ext_write: cover property (bus_done_q && cur_we_q && !int_q);
  c_ram_access: cover property (bus_done_q && int_q);

endmodule : mlmb_core

// ---- core/mlmb_defs.svh ----
/*
  Constants for the mode latch and multiplexed bus block: register offsets,
  field positions, reset values, mode codes, widths and timing figures.
  Assumes it is included by bare name, once or more, from any design file.
*/
`ifndef MLMB_DEFS_SVH
`define MLMB_DEFS_SVH

// Register port offsets
`define MLMB_REG_AW         5
`define MLMB_OFF_P1_DDR     5'h00
`define MLMB_OFF_P2_DDR     5'h01
`define MLMB_OFF_P1_DATA    5'h02
`define MLMB_OFF_P2_DATA    5'h03

// Port two data and mode register fields
`define MLMB_P2D_ZERO_BIT   7
`define MLMB_P2D_MODE_HI    6
`define MLMB_P2D_MODE_LO    5

// Port widths
`define MLMB_P1_W           8
`define MLMB_P2_W           5
`define MLMB_P3_W           10
`define MLMB_P4_W           8
`define MLMB_AD_W           8
`define MLMB_ADDR_W         16

// Port three control lines above the multiplexed byte
`define MLMB_P3_RW_BIT      8
`define MLMB_P3_EXT_BIT     9

// Mode codes as sampled from the two select pins
`define MLMB_MODE_MUX_NORAM 2'h3
`define MLMB_MODE_MUX_RAM   2'h2

// Internal RAM window, enabled only in the RAM mode
`define MLMB_RAM_AW         7
`define MLMB_RAM_DEPTH      128
`define MLMB_RAM_BASE_HI    9'h001

// Reset values
`define MLMB_P3_OUT_RST     10'h100
`define MLMB_BYTE_RST       8'h00

// Timing kept by the surrounding system: clock period in ns, reset and mode setup in E cycles
`define MLMB_CLK_NS         25
`define MLMB_RESET_LOW_MIN_WIDTH_E   3
`define MLMB_MODE_SETUP_INTERVAL_E   2

`endif

// ---- core/mlmb_pkg.sv ----
/*
  Types shared by the mode latch and multiplexed bus block.
  Assumes mlmb_defs.svh is available for the numeric constants.
*/
package mlmb_pkg;

  // Phases of one multiplexed bus cycle
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_DATA
  } mlmb_bus_state_t;

endpackage : mlmb_pkg

// ---- core/mlmb_ram.sv ----
/*
  Internal RAM of 128 bytes, one write port and one registered read port.
  Assumes a single clock; address and write enable come from the bus engine.
*/
`timescale 1ns/1ps
`include "mlmb_defs.svh"

module mlmb_ram
  import mlmb_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      ce,
  input  wire logic                      we,
  input  wire logic [`MLMB_RAM_AW-1:0]   addr,
  input  wire logic [`MLMB_AD_W-1:0]     wdata,
  output logic      [`MLMB_AD_W-1:0]     rdata_q
);

  logic [`MLMB_AD_W-1:0] mem [0:`MLMB_RAM_DEPTH-1];

  // No reset on the array; contents are undefined after power up
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata_q <= mem[addr];
    end
  end

endmodule : mlmb_ram

// ---- verification/mlmb_core_tb.sv ----
/*
  Self-checking bench for the mode latch and multiplexed bus core.
  Assumes the external bus model and the design files are compiled first.
*/
`timescale 1ns/1ps
`include "mlmb_defs.svh"

module mlmb_core_tb;
  import mlmb_pkg::*;

  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        bus_req = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic        bus_we = 1'b0;
  logic [7:0]  bus_wdata = 8'h00;
  logic [7:0]  p1_ext = 8'h00;
  logic [4:0]  p2_ext = 5'h03;
  logic [1:0]  mode = 2'h3;
  logic        ce = 1'b1;
  wire  [7:0]  reg_rdata_q, bus_rdata_q, p1_out, p1_oe, p4_out, lat_lo, seen_hi;
  wire  [4:0]  p2_out, p2_oe;
  wire  [9:0]  p3_in, p3_out, p3_oe;
  wire  [1:0]  mode_bits_q;
  wire         busy, bus_done_q, ram_enable_q, mode_undefined_q, e_clk, as_pin;
  wire  [7:0]  p1_pin = (p1_oe & p1_out) | (~p1_oe & p1_ext);
  wire  [4:0]  p2_pin = (p2_oe & p2_out) | (~p2_oe & p2_ext);
  int          ext_wr;
  int          fails = 0;
  int          checks = 0;
  int          seed = 46;

  always #12.5 clk = ~clk;

  mlmb_core u_mlmb_core (.clk(clk), .reset_n(reset_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .bus_req(bus_req), .bus_addr(bus_addr), .bus_we(bus_we),
    .bus_wdata(bus_wdata), .bus_busy_q(busy), .bus_done_q(bus_done_q),
    .bus_rdata_q(bus_rdata_q), .e_clk(e_clk), .address_latch_strobe(as_pin),
    .port_one_in(p1_pin), .port_one_out_q(p1_out), .port_one_oe_q(p1_oe),
    .port_two_in(p2_pin), .port_two_out_q(p2_out), .port_two_oe_q(p2_oe),
    .port_three_in(p3_in), .port_three_out_q(p3_out), .port_three_oe_q(p3_oe),
    .port_four_out_q(p4_out), .mode_bits_q(mode_bits_q), .ram_enable_q(ram_enable_q),
    .mode_undefined_q(mode_undefined_q));

  mlmb_ext_bus_model u_mlmb_ext_bus_model (.clk(clk), .p3_out(p3_out), .p3_oe(p3_oe),
    .p4_out(p4_out), .p3_in(p3_in), .e_clk(e_clk), .as_pin(as_pin), .lat_lo(lat_lo),
    .seen_hi(seen_hi), .ext_wr(ext_wr));

  // Pin level seen by a read: own data on outputs, outside level on inputs
  function automatic logic [7:0] exp_pin(input logic [7:0] ddr, dat, ext);
    return (ddr & dat) | (~ddr & ext);
  endfunction : exp_pin

  function automatic logic [7:0] exp_p2(input logic [1:0] m, input logic [4:0] pins);
    return {1'b0, m, pins};
  endfunction : exp_p2

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Mode pins set as reset falls; the model's E period is 40 clocks, so reset
  // spans three E cycles plus margin, which also covers the mode setup time
  task automatic do_reset(input logic [1:0] m);
    reset_n <= 1'b0;
    mode <= m;
    p2_ext <= {3'($random(seed)), m};
    repeat (`MLMB_RESET_LOW_MIN_WIDTH_E * 40 + 10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(mode_bits_q, m, "mode bits");
    chk(ram_enable_q, m == 2'h2, "ram enable");
    chk(mode_undefined_q, 1'b0, "mode flag");
    @(posedge clk);
  endtask : do_reset

  // One idle cycle after each strobe keeps drives single per time step
  task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : reg_write

  task automatic reg_read(input logic [4:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
    @(posedge clk);
  endtask : reg_read

  task automatic bus_xfer(input logic [15:0] a, input logic we, input logic [7:0] wd,
                          output logic [7:0] rd);
    int n;
    bus_addr <= a;
    bus_we <= we;
    bus_wdata <= wd;
    bus_req <= 1'b1;
    @(posedge clk);
    bus_req <= 1'b0;
    #1;
    chk(busy, 1'b1, "busy after request");
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      #1;
      if (bus_done_q === 1'b1) break;
    end
    if (n == 200) begin
      fails++;
      $display("FAIL %0t bus cycle never ended", $time);
      end_sim();
    end
    chk(busy, 1'b0, "busy after done");
    rd = bus_rdata_q;
    @(posedge clk);
  endtask : bus_xfer

  initial begin
    logic [7:0]  ddr, dat, r;
    logic [15:0] a;
    int          w0;
    repeat (2) @(posedge clk);
    do_reset(2'h3);
    // Port registers: all-input, all-output, then random directions
    for (int i = 0; i < 5; i++) begin
      ddr = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      dat = 8'($random(seed));
      p1_ext <= 8'($random(seed));
      p2_ext <= 5'($random(seed));
      reg_write(`MLMB_OFF_P1_DDR, ddr);
      reg_write(`MLMB_OFF_P1_DATA, dat);
      reg_write(`MLMB_OFF_P2_DDR, ddr);
      reg_write(`MLMB_OFF_P2_DATA, dat);
      repeat (3) @(posedge clk);
      #1;
      chk(p1_oe, ddr, "p1 direction");
      chk(p2_oe, ddr[4:0], "p2 direction");
      @(posedge clk);
      reg_read(`MLMB_OFF_P1_DATA, r);
      chk(r, exp_pin(ddr, dat, p1_ext), "p1 data");
      reg_read(`MLMB_OFF_P1_DDR, r);
      chk(r, 8'h00, "p1 ddr read");
      reg_read(`MLMB_OFF_P2_DDR, r);
      chk(r, 8'h00, "p2 ddr read");
      reg_read(`MLMB_OFF_P2_DATA, r);
      chk(r, exp_p2(mode, 5'(exp_pin(ddr, dat, {3'h0, p2_ext}))), "p2 data");
      reg_read(5'h1f, r);
      chk(r, 8'h00, "unmapped read");
    end
    // Clock enable low: a direction write must not land
    ce <= 1'b0;
    reg_write(`MLMB_OFF_P1_DDR, ~ddr);
    ce <= 1'b1;
    #1;
    chk(p1_oe, ddr, "p1 direction frozen");
    @(posedge clk);
    $display("register test done");
    // Mode 3: every cycle goes outside, even in the RAM window
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 16'h0090 : (i == 1) ? 16'hffff : 16'($random(seed));
      dat = 8'($random(seed));
      w0 = ext_wr;
      bus_xfer(a, 1'b1, dat, r);
      chk(16'(ext_wr), 16'(w0 + 1), "external write count");
      chk(seen_hi, a[15:8], "high address");
      chk(lat_lo, a[7:0], "latched low address");
      bus_xfer(a, 1'b0, 8'h00, r);
      chk(r, dat, "external read");
    end
    $display("mode 3 bus test done");
    // Mode 2 after a second reset: RAM window stays inside
    do_reset(2'h2);
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 16'h0080 : (i == 1) ? 16'h00ff : {8'h00, 1'b1, 7'($random(seed))};
      dat = 8'($random(seed));
      w0 = ext_wr;
      bus_xfer(a, 1'b1, dat, r);
      bus_xfer(a, 1'b0, 8'h00, r);
      chk(r, dat, "internal ram read");
      chk(16'(ext_wr), 16'(w0), "no external write");
      a = (i == 0) ? 16'h0100 : 16'h007f;
      bus_xfer(a, 1'b1, ~dat, r);
      chk(16'(ext_wr), 16'(w0 + 1), "outside ram window");
      chk(seen_hi, a[15:8], "high address");
    end
    p2_ext <= 5'h01;
    repeat (4) @(posedge clk);
    #1;
    chk(mode_bits_q, 2'h2, "mode bits hold");
    $display("mode 2 bus test done");
    end_sim();
  end
endmodule : mlmb_core_tb

// ---- verification/mlmb_ext_bus_model.sv ----
/*
  Far side of the multiplexed bus: E and strobe source, address latch and
  a 256-byte external memory. Assumes the core's clock drives it as well.
*/
`timescale 1ns/1ps
`include "mlmb_defs.svh"

module mlmb_ext_bus_model (
  input  wire logic                  clk,
  input  wire logic [`MLMB_P3_W-1:0] p3_out,
  input  wire logic [`MLMB_P3_W-1:0] p3_oe,
  input  wire logic [`MLMB_P4_W-1:0] p4_out,
  output logic      [`MLMB_P3_W-1:0] p3_in,
  output logic                       e_clk,
  output logic                       as_pin,
  output logic      [`MLMB_AD_W-1:0] lat_lo,
  output logic      [`MLMB_P4_W-1:0] seen_hi,
  output int                         ext_wr
);
  logic [5:0]            cnt  = 6'h00;
  logic [2:0]            hold = 3'h0;
  logic [`MLMB_P3_W-1:0] last = 10'h000;
  logic [`MLMB_AD_W-1:0] mem [256];
  logic                  drv;

  // Preset memory so reads never see leftovers
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    e_clk = 1'b0;
    as_pin = 1'b0;
    lat_lo = 8'h00;
    seen_hi = 8'h00;
    ext_wr = 0;
  end

  // Free-running E, strobe pulse ahead of each high phase
  always @(posedge clk) begin
    cnt <= (cnt == 6'd39) ? 6'd0 : cnt + 6'd1;
    as_pin <= (cnt >= 6'd1 && cnt < 6'd9);
    e_clk <= (cnt >= 6'd13 && cnt < 6'd33);
  end

  // Address latch transparent while strobe is high; writes taken as E falls
  always @(posedge clk) begin
    // Remember what the core last drove; unknowns before reset are skipped
    foreach (last[b]) begin
      if (p3_oe[b] === 1'b1) begin
        last[b] <= p3_out[b];
      end
    end
    hold <= e_clk ? 3'h4 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
    if (as_pin) begin
      lat_lo <= p3_in[7:0];
      seen_hi <= p4_out;
    end
    if (cnt == 6'd33 && !p3_out[`MLMB_P3_RW_BIT] && p3_out[`MLMB_P3_EXT_BIT]) begin
      mem[lat_lo] <= p3_in[7:0];
      ext_wr <= ext_wr + 1;
    end
  end

  // Drive only during E high plus a short hold; released lines show the inverse
  assign drv = p3_out[`MLMB_P3_RW_BIT] && p3_out[`MLMB_P3_EXT_BIT]
               && (e_clk || hold != 3'h0);
  assign p3_in = (p3_oe & p3_out)
               | (~p3_oe & (drv ? {~last[9:8], mem[lat_lo]} : ~last));
endmodule : mlmb_ext_bus_model
